//--- core/gate_pulse_ctrl.sv
`timescale 1ns/1ns
module gate_pulse_ctrl (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic spm_en,
   input  wire logic arm_set,
   input  wire logic arm_clr,
   input  wire logic gate_val,
   output logic      arm_done,
   output logic      sp_active
);
   gate_pkg::sp_state_e state_r;
   gate_pkg::sp_state_e state_nxt;
   logic                gv_d_r;
   logic                arm_r;
   logic                arm_nxt;
   logic                rise;
   logic                fall;

   assign rise = gate_val && !gv_d_r;
   assign fall = !gate_val && gv_d_r;

   always_comb begin
      state_nxt = state_r;
      arm_nxt   = arm_r;
      if (arm_clr) begin
         arm_nxt = 1'b0;
      end
      // arming is refused unless single-pulse was enabled first
      if (arm_set && spm_en) begin
         arm_nxt = 1'b1; // R1
      end
      case (state_r)
         gate_pkg::SP_IDLE: begin
            if (arm_nxt && spm_en) begin
               state_nxt = gate_pkg::SP_WAIT;
            end
         end
         gate_pkg::SP_WAIT: begin
            if (!arm_nxt || !spm_en) begin
               state_nxt = gate_pkg::SP_IDLE;
            end else if (rise) begin
               state_nxt = gate_pkg::SP_PULSE; // R2
            end
         end
         gate_pkg::SP_PULSE: begin
            if (!spm_en || !arm_nxt) begin
               state_nxt = gate_pkg::SP_IDLE;
            end else if (fall) begin
               arm_nxt   = 1'b0; // R3
               state_nxt = gate_pkg::SP_IDLE; // R4
            end
         end
         default: state_nxt = gate_pkg::SP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= gate_pkg::SP_IDLE;
         arm_r   <= 1'b0;
         gv_d_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         arm_r   <= arm_nxt;
         gv_d_r  <= gate_val;
      end
   end

   assign arm_done  = arm_r;
   // gate is live only from the captured rising edge to its fall
   assign sp_active = (state_r == gate_pkg::SP_PULSE) && gate_val; // R16

   done_on_fall_a: assert property (@(posedge clk) disable iff (rst) // R3
      (state_r == gate_pkg::SP_PULSE && fall && spm_en && !arm_clr)
      |=> !arm_r)
      else $error("arm flag not cleared at pulse end");
   start_on_rise_a: assert property (@(posedge clk) disable iff (rst) // R2
      (state_r == gate_pkg::SP_WAIT && rise && arm_r && spm_en
       && !arm_clr) |=> state_r == gate_pkg::SP_PULSE)
      else $error("pulse capture did not start");
   no_rearm_a: assert property (@(posedge clk) disable iff (rst) // R4
      (!arm_r && !arm_set) |=> state_r != gate_pkg::SP_PULSE)
      else $error("capture without arming");
   c_pulse_done: cover property (@(posedge clk) disable iff (rst)
      state_r == gate_pkg::SP_PULSE ##1 state_r == gate_pkg::SP_IDLE);
endmodule // gate_pulse_ctrl

//--- core/gate_select.sv
`timescale 1ns/1ns
module gate_select (
   input  wire logic clk,
   input  wire logic rst,
   gate_if.src       g
);
   logic chosen;
   logic pol_val;
   logic pol_d_r;
   logic tog_r;
   logic tog_nxt;

   always_comb begin
      case (gate_pkg::gate_src_e'(g.src_sel)) // R14
         gate_pkg::SRC_PIN:  chosen = g.gate_pin_sync;
         gate_pkg::SRC_OVF:  chosen = g.ovf_pulse;
         gate_pkg::SRC_CMP1: chosen = g.cmp1_out;
         gate_pkg::SRC_CMP2: chosen = g.cmp2_out;
         default:            chosen = 1'b0;
      endcase
      pol_val = chosen ^ g.polarity; // R15
      tog_nxt = tog_r;
      if (!g.toggle_en) begin
         tog_nxt = 1'b0; // R13
      end else if (pol_val && !pol_d_r) begin
         tog_nxt = ~tog_r; // R12
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pol_d_r <= 1'b0;
         tog_r   <= 1'b0;
      end else begin
         pol_d_r <= pol_val;
         tog_r   <= tog_nxt;
      end
   end

   assign g.gate_val = g.toggle_en ? tog_r : pol_val;

   toggle_clear_a: assert property (@(posedge clk) disable iff (rst) // R13
      !g.toggle_en |=> !tog_r)
      else $error("toggle flip-flop not held clear");
endmodule // gate_select

//--- core/timer_gate_pulse_control.sv
// What this block does
// R1: software sets pulse enable before arming
// R2: armed timer starts on next gate rise
// R3: arm flag clears at pulse trailing edge
// R4: no counting after done until rearmed
// R5: software clears arm when disabling pulse
// R6: toggle plus pulse measures full cycle
// R7: gate level readable as status bit
// R8: gate level valid with gate disabled
// R9: gate level fall sets event flag
// R10: enabled event flag raises interrupt
// R11: event flag works with gate disabled
// R12: toggle flip-flop flips on rising edge
// R13: toggle flip-flop cleared when disabled
// R14: two-bit select picks gate source
// R15: polarity bit inverts chosen source
// R16: armed pulse counts only during pulse
`timescale 1ns/1ns
`include "gate_params.svh"
module timer_gate_pulse_control #(
   parameter int CNT_W = 16
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              gate_input_pin,
   input  wire logic              ovf_pulse,
   input  wire logic              cmp1_out,
   input  wire logic              cmp2_out,
   input  wire logic              count_tick,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq
);
   logic [7:0]       ctrl_r;
   logic [7:0]       ctrl_nxt;
   logic             flag_r;
   logic             flag_nxt;
   logic             irq_en_r;
   logic             irq_en_nxt;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [31:0]      prdata_r;
   logic [31:0]      prdata_nxt;
   logic             pready_r;
   logic             pready_nxt;
   logic             pslverr_r;
   logic             pslverr_nxt;
   logic             irq_r;
   logic             irq_nxt;
   logic             pin_s1_r;
   logic             pin_s2_r;
   logic             gv_d_r;
   logic             wr_acc;
   logic             rd_acc;
   logic             mapped;
   logic             arm_set;
   logic             arm_clr;
   logic             arm_done;
   logic             sp_active;
   logic             gate_open;
   logic             gate_fall;

   gate_if gi ();

   // the pin is asynchronous: two flops before anything looks at it
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= gate_input_pin;
         pin_s2_r <= pin_s1_r;
      end
   end

   assign gi.gate_pin_sync = pin_s2_r;
   assign gi.ovf_pulse     = ovf_pulse;
   assign gi.cmp1_out      = cmp1_out;
   assign gi.cmp2_out      = cmp2_out;
   assign gi.src_sel       = ctrl_r[`CTRL_SRC_LO +: 2]; // R14
   assign gi.polarity      = ctrl_r[`CTRL_POL_BIT]; // R15
   assign gi.toggle_en     = ctrl_r[`CTRL_TOGGLE_BIT]; // R12

   gate_select u_sel (
      .clk (clk),
      .rst (rst),
      .g   (gi.src)
   );

   // toggle output feeds the pulse controller, so one pulse spans a cycle
   gate_pulse_ctrl u_pulse (
      .clk       (clk),
      .rst       (rst),
      .spm_en    (ctrl_r[`CTRL_SPM_BIT]),
      .arm_set   (arm_set),
      .arm_clr   (arm_clr),
      .gate_val  (gi.gate_val), // R6
      .arm_done  (arm_done),
      .sp_active (sp_active)
   );

   // setup is decoded a cycle early so that pready and read data are
   // registered; the access phase therefore always lasts one cycle and
   // a write only lands at the edge where pready is seen high
   assign wr_acc = psel && penable && pwrite && pready_r;
   assign rd_acc = psel && !penable && !pwrite;
   assign mapped = (paddr == `CTRL_ADDR) || (paddr == `STATUS_ADDR)
                || (paddr == `FLAG_ADDR) || (paddr == `IRQ_EN_ADDR)
                || (paddr == `COUNT_ADDR);
   assign arm_set = wr_acc && (paddr == `CTRL_ADDR)
                 && pwdata[`CTRL_ARM_BIT];
   // R5 is software's duty; a write of zero here is what honours it
   assign arm_clr = wr_acc && (paddr == `CTRL_ADDR)
                 && !pwdata[`CTRL_ARM_BIT]; // R5
   assign gate_fall = gv_d_r && !gi.gate_val; // R9

   // with the gate disabled the counter runs free; the level and the
   // event flag keep working regardless
   always_comb begin
      if (!ctrl_r[`CTRL_GATE_EN_BIT]) begin
         gate_open = 1'b1;
      end else if (ctrl_r[`CTRL_SPM_BIT]) begin
         gate_open = sp_active; // R16
      end else begin
         gate_open = gi.gate_val;
      end
   end

   always_comb begin
      ctrl_nxt    = ctrl_r;
      flag_nxt    = flag_r;
      irq_en_nxt  = irq_en_r;
      count_nxt   = count_r;
      prdata_nxt  = prdata_r;
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      if (psel && !penable) begin
         pready_nxt  = 1'b1;
         pslverr_nxt = !mapped;
      end
      if (rd_acc) begin
         prdata_nxt = 32'h0000_0000;
         case (paddr)
            `CTRL_ADDR: begin
               prdata_nxt[7:0]           = ctrl_r;
               prdata_nxt[`CTRL_ARM_BIT] = arm_done;
            end
            `STATUS_ADDR: prdata_nxt[`STAT_LEVEL_BIT] = gi.gate_val; // R7
            `FLAG_ADDR:   prdata_nxt[`FLAG_GATE_BIT]  = flag_r;
            `IRQ_EN_ADDR: prdata_nxt[`FLAG_GATE_BIT]  = irq_en_r;
            `COUNT_ADDR:  prdata_nxt[CNT_W-1:0]       = count_r;
            default:      prdata_nxt = 32'h0000_0000;
         endcase
      end
      if (wr_acc) begin
         case (paddr)
            `CTRL_ADDR:   ctrl_nxt = pwdata[7:0];
            `FLAG_ADDR: begin
               if (pwdata[`FLAG_GATE_BIT]) begin
                  flag_nxt = 1'b0;
               end
            end
            `IRQ_EN_ADDR: irq_en_nxt = pwdata[`FLAG_GATE_BIT];
            `COUNT_ADDR:  count_nxt = pwdata[CNT_W-1:0];
            default:      ;
         endcase
      end
      ctrl_nxt[`CTRL_ARM_BIT] = 1'b0;
      // independent of the gate enable; set beats a same-cycle clear
      if (gate_fall) begin
         flag_nxt = 1'b1; // R11
      end
      if (ctrl_r[`CTRL_RUN_BIT] && gate_open && count_tick) begin
         count_nxt = count_r + 1'b1;
      end
      irq_nxt = flag_nxt && irq_en_nxt; // R10
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r    <= `CTRL_RESET;
         flag_r    <= 1'b0;
         irq_en_r  <= 1'b0;
         count_r   <= `COUNT_RESET;
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r     <= 1'b0;
         gv_d_r    <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         flag_r    <= flag_nxt;
         irq_en_r  <= irq_en_nxt;
         count_r   <= count_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         irq_r     <= irq_nxt;
         gv_d_r    <= gi.gate_val;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign irq     = irq_r;

   // the event flag follows a fall of the gate level on the next edge
   flag_on_fall_a: assert property (@(posedge clk) disable iff (rst) // R9
      gate_fall |=> flag_r)
      else $error("gate fall did not set event flag");
   flag_gate_off_a: assert property (@(posedge clk) disable iff (rst) // R11
      (gate_fall && !ctrl_r[`CTRL_GATE_EN_BIT]) |=> flag_r)
      else $error("flag lost with gate disabled");
   // only a fall sets the flag and only a bus write may clear it
   flag_hold_a: assert property (@(posedge clk) disable iff (rst) // R9
      (!gate_fall && !wr_acc) |=> flag_r == $past(flag_r))
      else $error("event flag changed without cause");
   irq_follows_a: assert property (@(posedge clk) disable iff (rst) // R10
      (flag_r && irq_en_r) |=> ##0 (irq_r || $past(wr_acc)))
      else $error("interrupt missing");
   irq_masked_a: assert property (@(posedge clk) disable iff (rst) // R10
      (!irq_en_r && !wr_acc) |=> !irq_r)
      else $error("interrupt raised while masked");
   irq_no_flag_a: assert property (@(posedge clk) disable iff (rst) // R10
      (!flag_r && !gate_fall) |=> !irq_r)
      else $error("interrupt raised without flag");
   level_read_a: assert property (@(posedge clk) disable iff (rst) // R8
      (rd_acc && paddr == `STATUS_ADDR)
      |=> prdata_r[0] == $past(gi.gate_val))
      else $error("gate level read wrong");
   arm_read_a: assert property (@(posedge clk) disable iff (rst) // R3
      (rd_acc && paddr == `CTRL_ADDR)
      |=> prdata_r[`CTRL_ARM_BIT] == $past(arm_done))
      else $error("arm flag read wrong");
   // with the toggle off the level is the chosen source after polarity
   src_pin_a: assert property (@(posedge clk) disable iff (rst) // R14
      (!gi.toggle_en && gi.src_sel == 2'h0)
      |-> gi.gate_val == (pin_s2_r ^ gi.polarity))
      else $error("pin source level wrong");
   src_ovf_a: assert property (@(posedge clk) disable iff (rst) // R14
      (!gi.toggle_en && gi.src_sel == 2'h1)
      |-> gi.gate_val == (ovf_pulse ^ gi.polarity))
      else $error("overflow source level wrong");
   src_cmp1_a: assert property (@(posedge clk) disable iff (rst) // R15
      (!gi.toggle_en && gi.src_sel == 2'h2)
      |-> gi.gate_val == (cmp1_out ^ gi.polarity))
      else $error("first comparator level wrong");
   src_cmp2_a: assert property (@(posedge clk) disable iff (rst) // R15
      (!gi.toggle_en && gi.src_sel == 2'h3)
      |-> gi.gate_val == (cmp2_out ^ gi.polarity))
      else $error("second comparator level wrong");
   hold_count_a: assert property (@(posedge clk) disable iff (rst) // R16
      (ctrl_r[`CTRL_GATE_EN_BIT] && ctrl_r[`CTRL_SPM_BIT] && !sp_active
       && !wr_acc) |=> $stable(count_r))
      else $error("count moved outside captured pulse");
   // inside the captured pulse every tick must reach the counter
   count_step_a: assert property (@(posedge clk) disable iff (rst) // R16
      (ctrl_r[`CTRL_RUN_BIT] && ctrl_r[`CTRL_GATE_EN_BIT]
       && ctrl_r[`CTRL_SPM_BIT] && sp_active && count_tick && !wr_acc)
      |=> count_r == $past(count_r) + 1'b1)
      else $error("count did not advance inside pulse");
   // the bus answer is a single-cycle pulse, the error rides with it
   ready_pulse_a: assert property (@(posedge clk) disable iff (rst)
      pready_r |=> !pready_r)
      else $error("ready held longer than one cycle");
   err_ready_a: assert property (@(posedge clk) disable iff (rst)
      pslverr_r |-> pready_r)
      else $error("error reported without ready");
   c_arm_done: cover property (@(posedge clk) disable iff (rst)
      $fell(arm_done));
   c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq_r));
   c_count: cover property (@(posedge clk) disable iff (rst)
      sp_active && count_tick);
   c_toggle: cover property (@(posedge clk) disable iff (rst)
      ctrl_r[`CTRL_TOGGLE_BIT] && gate_fall);
endmodule // timer_gate_pulse_control

//--- pkg/gate_if.sv
`timescale 1ns/1ns
interface gate_if;
   logic       gate_pin_sync;
   logic       ovf_pulse;
   logic       cmp1_out;
   logic       cmp2_out;
   logic [1:0] src_sel;
   logic       polarity;
   logic       toggle_en;
   logic       gate_val;

   modport src (
      input  gate_pin_sync, ovf_pulse, cmp1_out, cmp2_out,
      input  src_sel, polarity, toggle_en,
      output gate_val
   );
   modport ctl (
      output gate_pin_sync, ovf_pulse, cmp1_out, cmp2_out,
      output src_sel, polarity, toggle_en,
      input  gate_val
   );
endinterface

//--- pkg/gate_params.svh
`ifndef GATE_PARAMS_SVH
`define GATE_PARAMS_SVH

// register byte addresses
`define CTRL_ADDR      12'h000
`define STATUS_ADDR    12'h004
`define FLAG_ADDR      12'h008
`define IRQ_EN_ADDR    12'h00c
`define COUNT_ADDR     12'h010

// control register fields
`define CTRL_GATE_EN_BIT   7
`define CTRL_POL_BIT       6
`define CTRL_TOGGLE_BIT    5
`define CTRL_SPM_BIT       4
`define CTRL_ARM_BIT       3
`define CTRL_RUN_BIT       2
`define CTRL_SRC_LO        0

// status register fields
`define STAT_LEVEL_BIT     0

// flag / irq enable fields
`define FLAG_GATE_BIT      0

`define CTRL_RESET         8'h00
`define COUNT_RESET        16'h0000

`endif

//--- pkg/gate_pkg.sv
package gate_pkg;
   typedef enum logic [1:0] {
      SRC_PIN,
      SRC_OVF,
      SRC_CMP1,
      SRC_CMP2
   } gate_src_e;

   typedef enum {
      SP_IDLE,
      SP_WAIT,
      SP_PULSE
   } sp_state_e;
endpackage

//--- sim/gate_source_model.sv
`timescale 1ns/1ns
module gate_source_model (
   input  wire logic clk,
   output logic      gate_input_pin,
   output logic      ovf_pulse,
   output logic      cmp1_out,
   output logic      cmp2_out
);
   initial begin
      gate_input_pin = 1'b0;
      ovf_pulse = 1'b0;
      cmp1_out = 1'b0;
      cmp2_out = 1'b0;
   end

   // one source changes just after an edge, the others keep their level
   task automatic drive(input logic [1:0] s, input logic v);
      @(posedge clk);
      case (s)
         2'h0: gate_input_pin <= v;
         2'h1: ovf_pulse <= v;
         2'h2: cmp1_out <= v;
         default: cmp2_out <= v;
      endcase
   endtask

   // overflow only ever arrives as a single-cycle pulse
   task automatic ovf_tick();
      drive(2'h1, 1'b1);
      drive(2'h1, 1'b0);
   endtask
endmodule // gate_source_model

//--- sim/tb_timer_gate_pulse_control.sv
`timescale 1ns/1ns
`include "gate_params.svh"
module tb_timer_gate_pulse_control;
   logic        clk;
   logic        rst;
   logic        count_tick;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        pin;
   logic        ovf;
   logic        cmp1;
   logic        cmp2;
   logic [31:0] rv;
   logic        re;
   logic [15:0] c0;
   logic        lv;
   int          n_errors;
   int          checks_done;
   int          seed;
   int          w;
   int          l;

   gate_source_model gate_source_model_inst (.clk(clk), .gate_input_pin(pin),
      .ovf_pulse(ovf), .cmp1_out(cmp1), .cmp2_out(cmp2));

   timer_gate_pulse_control timer_gate_pulse_control_inst (.clk(clk),
      .rst(rst), .gate_input_pin(pin), .ovf_pulse(ovf), .cmp1_out(cmp1),
      .cmp2_out(cmp2), .count_tick(count_tick), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic report_and_stop();
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   function automatic logic [31:0] lvl_exp(input logic v, input logic p);
      return {31'h0, v ^ p};
   endfunction

   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] got);
      checks_done++;
      if (got !== x) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, x, got);
      end
   endtask

   // gate sync latency may shift the window by one tick either way
   task automatic cnt_chk(input string nm, input logic [15:0] lo);
      apb(1'b0, `COUNT_ADDR, 32'h0);
      checks_done++;
      if ((rv[15:0] >= lo - 16'h1 && rv[15:0] <= lo + 16'h1) !== 1'b1) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, lo, rv[15:0]);
      end
   endtask

   task automatic apb(input logic w_, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w_;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x,
                     input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, x, rv);
   endtask

   task automatic hi(input int n);
      gate_source_model_inst.drive(2'h0, 1'b1);
      repeat (n - 1) @(posedge clk);
      gate_source_model_inst.drive(2'h0, 1'b0);
      repeat (6) @(posedge clk);
   endtask

   task automatic irq_chk(input logic x);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("irq", {31'h0, x}, {31'h0, irq});
   endtask

   initial begin
      #400000;
      n_errors++;
      report_and_stop();
   end

   initial begin
      seed = 78;
      n_errors = 0;
      checks_done = 0;
      rst = 1'b1;
      count_tick = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(`CTRL_ADDR, 32'h0, "ctrl");
      rd(`FLAG_ADDR, 32'h0, "flag");
      rd(`COUNT_ADDR, 32'h0, "count");
      apb(1'b0, 12'h040, 32'h0);
      chk("unmapped", 32'h1, {31'h0, re});
      wr(`CTRL_ADDR, 32'h8);
      rd(`CTRL_ADDR, 32'h0, "arm_no_spm");
      for (int s = 0; s < 4; s++) begin
         for (int p = 0; p < 2 && s != 1; p++) begin
            lv = 1'($random(seed));
            wr(`CTRL_ADDR, 32'(p * 64 + s));
            gate_source_model_inst.drive(2'(s), lv);
            repeat (4) @(posedge clk);
            rd(`STATUS_ADDR, lvl_exp(lv, 1'(p)), "level");
         end
      end
      wr(`CTRL_ADDR, 32'h1);
      repeat (4) @(posedge clk);
      wr(`FLAG_ADDR, 32'h1);
      rd(`FLAG_ADDR, 32'h0, "flag_clr");
      gate_source_model_inst.ovf_tick();
      repeat (4) @(posedge clk);
      rd(`FLAG_ADDR, 32'h1, "flag_set");
      irq_chk(1'b0);
      wr(`IRQ_EN_ADDR, 32'h1);
      irq_chk(1'b1);
      wr(`FLAG_ADDR, 32'h1);
      irq_chk(1'b0);
      gate_source_model_inst.drive(2'h0, 1'b0);
      wr(`CTRL_ADDR, 32'h94);
      wr(`CTRL_ADDR, 32'h9c);
      apb(1'b0, `COUNT_ADDR, 32'h0);
      c0 = rv[15:0];
      repeat (5) @(posedge clk);
      rd(`COUNT_ADDR, {16'h0, c0}, "hold_before");
      w = 4 + ($random(seed) & 7);
      hi(w);
      cnt_chk("pulse_count", c0 + 16'(w));
      rd(`CTRL_ADDR, 32'h94, "arm_done");
      apb(1'b0, `COUNT_ADDR, 32'h0);
      c0 = rv[15:0];
      hi(w);
      rd(`COUNT_ADDR, {16'h0, c0}, "no_rearm");
      wr(`CTRL_ADDR, 32'h84);
      wr(`CTRL_ADDR, 32'hb4);
      wr(`CTRL_ADDR, 32'hbc);
      apb(1'b0, `COUNT_ADDR, 32'h0);
      c0 = rv[15:0];
      w = 3 + ($random(seed) & 7);
      l = 3 + ($random(seed) & 7);
      gate_source_model_inst.drive(2'h0, 1'b1);
      repeat (w - 1) @(posedge clk);
      gate_source_model_inst.drive(2'h0, 1'b0);
      repeat (l - 1) @(posedge clk);
      hi(3);
      cnt_chk("cycle_count", c0 + 16'(w + l));
      rd(`CTRL_ADDR, 32'hb4, "cycle_done");
      wr(`CTRL_ADDR, 32'h20);
      hi(3);
      rd(`STATUS_ADDR, 32'h1, "toggle_on");
      wr(`CTRL_ADDR, 32'h0);
      repeat (4) @(posedge clk);
      rd(`STATUS_ADDR, 32'h0, "toggle_off");
      report_and_stop();
   end
endmodule // tb_timer_gate_pulse_control
